// ==== hw/aosc_map.svh ====
/*
 Constant map of the axis override and stop control block: error codes,
 speed limits, widths and reset values.
 Assumes inclusion by its bare name from the package and design modules.
*/
`ifndef AOSC_MAP_SVH
`define AOSC_MAP_SVH

// ****************************************************************
// Error codes.
// ****************************************************************
`define AOSC_ERR_NONE      16'h0000
`define AOSC_ERR_POS_OVR   16'h016a
`define AOSC_ERR_SPD_OVR   16'h0179
`define AOSC_ERR_ESTOP     16'h01e1
`define AOSC_ERR_EXT_UP    16'h01ec
`define AOSC_ERR_EXT_LO    16'h01ed
`define AOSC_ERR_EXT_DIR   16'h01ef
`define AOSC_ERR_SW_UP     16'h01f5
`define AOSC_ERR_SW_LO     16'h01f6

// ****************************************************************
// Speed limits in pulses per second.
// ****************************************************************
`define AOSC_SPD_MIN       32'h00000001
`define AOSC_SPD_MAX       32'h000186a0

// ****************************************************************
// Widths and reset values.
// ****************************************************************
`define AOSC_POS_W         32
`define AOSC_ERR_W         16
`define AOSC_SPD_RST       32'h00000000

`endif

// ==== hw/aosc_pkg.sv ====
/*
 Types shared by the axis override and stop control block.
 Assumes aosc_map.svh is on the include path.
*/
`include "aosc_map.svh"

package aosc_pkg;

  // ****************************************************************
  // Motion section of the running step.
  // ****************************************************************
  typedef enum logic [4:0] {
    SEC_IDLE  = 5'b00001,
    SEC_ACC   = 5'b00010,
    SEC_CONST = 5'b00100,
    SEC_DEC   = 5'b01000,
    SEC_DWELL = 5'b10000
  } aosc_sec_e;

  // ****************************************************************
  // Axis stop state.
  // ****************************************************************
  typedef enum logic [3:0] {
    ST_RUN    = 4'b0001,
    ST_DECSTP = 4'b0010,
    ST_HALT   = 4'b0100,
    ST_NOOUT  = 4'b1000
  } aosc_stop_e;

  // Operation mode of the axis.
  typedef enum logic [2:0] {
    MODE_POS   = 3'b001,
    MODE_SPEED = 3'b010,
    MODE_HOME  = 3'b100
  } aosc_mode_e;

  typedef logic signed [`AOSC_POS_W-1:0] aosc_pos_t;

endpackage

// ==== hw/aosc_pin_sync.sv ====
/*
 Three flip-flop synchroniser with agreement filter for pin inputs.
 Assumes a single clock domain clk_sys and synchronous reset.
*/
`timescale 1ns/10ps

module aosc_pin_sync #(
  parameter int WIDTH = 4
) (
  // Clock and reset.
  input  wire logic             clk_sys,
  input  wire logic             rst,
  // Pins in, filtered levels out.
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] levelOut
);

  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;
  logic [WIDTH-1:0] lvl_r;
  wire  [WIDTH-1:0] agree = ~(s2_r ^ s3_r);
  wire  [WIDTH-1:0] lvl_nxt = (agree & s2_r) | (~agree & lvl_r);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s1_r  <= '0;
      s2_r  <= '0;
      s3_r  <= '0;
      lvl_r <= '0;
    end else begin
      s1_r  <= pinIn;
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      lvl_r <= lvl_nxt;
    end
  end

  assign levelOut = lvl_r;

endmodule // aosc_pin_sync

// ==== hw/aosc_speed_sel.sv ====
/*
 Speed override value check and bias clamp.
 Assumes combinational use from the same clock domain.
*/
`timescale 1ns/10ps
`include "aosc_map.svh"

module aosc_speed_sel (
  // Requested and bias speed.
  input  wire logic [31:0] reqSpeed,
  input  wire logic [31:0] biasSpeed,
  // Checked result.
  output logic             inRange,
  output logic      [31:0] useSpeed
);

  // Values from 1 to 100000 pps are accepted.
  assign inRange = (reqSpeed >= `AOSC_SPD_MIN) &&
                   (reqSpeed <= `AOSC_SPD_MAX);
  // A target below bias runs at bias.
  assign useSpeed = (reqSpeed < biasSpeed) ? biasSpeed : reqSpeed;

endmodule // aosc_speed_sel

// ==== hw/aosc_axis_ctrl.sv ====
/*
 Per-axis override and stop control: position override, speed override,
 speed change at position, stop sources, priority, error code, no-output.
 Assumes a pulse generator that follows targetPos and runSpeed and reports
 its motion section, and pin-level limit inputs and an emergency stop command.
*/
`timescale 1ns/10ps
`include "aosc_map.svh"

module aosc_axis_ctrl
  import aosc_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Pins.
  input  wire logic        extUpperPin,
  input  wire logic        extLowerPin,
  input  wire logic        dogPin,
  input  wire logic        homePin,
  // Motion status from the pulse generator.
  input  wire logic [4:0]  section,
  input  wire logic [2:0]  opMode,
  input  wire logic        jogActive,
  input  wire logic        interpActive,
  input  wire logic        dirForward,
  input  wire logic        stepDone,
  input  wire logic        stopped,
  input  wire aosc_pos_t   curPos,
  input  wire logic [1:0]  patternSel,
  input  wire logic        absStep,
  input  wire logic        continuous_pattern,
  input  wire logic        modeEndContSeq,
  input  wire logic        homingDone,
  input  wire logic        originSet,
  // Parameters.
  input  wire logic [31:0] biasSpeed,
  input  wire aosc_pos_t   swUpper,
  input  wire aosc_pos_t   swLower,
  // Commands from the sequence program.
  input  wire logic        startCmd,
  input  wire aosc_pos_t   stepTarget,
  input  wire logic [31:0] stepSpeed,
  input  wire logic        restartSame,
  input  wire logic        posOverrideCmd,
  input  wire aosc_pos_t   posOverrideAmt,
  input  wire logic        speed_override_cmd,
  input  wire logic [31:0] speedOverrideVal,
  input  wire logic        speed_change_at_position_cmd,
  input  wire aosc_pos_t   pscPos,
  input  wire logic [31:0] pscSpeed,
  input  wire logic        decStopCmd,
  input  wire logic        estopCmd,
  input  wire logic        peerStop,
  input  wire logic        cancelNoOutCmd,
  // Results to the pulse generator and program.
  output aosc_pos_t        targetPos,
  output logic      [31:0] runSpeed,
  output logic             decelReq,
  output logic             haltReq,
  output logic             pulseEnable,
  output logic             stopPeers,
  output logic             posDone,
  output logic             auxAfterOn,
  output logic             auxCodeClr,
  output logic             noOutput,
  output logic             originValid,
  output logic             dogHomeUse,
  output logic      [15:0] errCode
);

  // ****************************************************************
  // Pin synchronisers.
  // ****************************************************************
  logic [3:0] pinLvl;

  aosc_pin_sync #(.WIDTH(4)) uSync (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .pinIn    ({homePin, dogPin, extLowerPin, extUpperPin}),
    .levelOut (pinLvl)
  );

  // ****************************************************************
  // Registers.
  // ****************************************************************
  aosc_stop_e  stop_r;
  aosc_stop_e  stop_nxt;
  aosc_pos_t   startPos_r;
  aosc_pos_t   target_r;
  aosc_pos_t   pscPos_r;
  logic [31:0] speed_r;
  logic [31:0] pscSpeed_r;
  logic        pscArm_r;
  logic        ovrPend_r;
  logic [15:0] err_r;
  logic        origin_r;
  logic [1:0]  extPrev_r;
  logic        done_r;
  logic        aux_r;
  logic        auxClr_r;
  logic        decStopped_r;

  // ****************************************************************
  // Decoding.
  // ****************************************************************
  wire secAcc   = section == SEC_ACC;
  wire secConst = section == SEC_CONST;
  wire secDec   = section == SEC_DEC;
  wire secDwell = section == SEC_DWELL;
  wire moving   = secAcc | secConst | secDec;
  wire running  = stop_r == ST_RUN;
  wire inHome   = opMode == MODE_HOME;
  wire inSpeed  = opMode == MODE_SPEED;

  // Override amount held as full signed 32-bit count.
  // Start point is the running step's own start, also in continuous.
  aosc_pos_t ovrTarget;
  assign ovrTarget = startPos_r + posOverrideAmt;

  function automatic logic passed(input aosc_pos_t pos, input aosc_pos_t tgt,
                                  input logic fwd);
    passed = fwd ? (pos > tgt) : (pos < tgt);
  endfunction

  wire posOvrOk  = posOverrideCmd & running & moving;
  wire posOvrErr = posOverrideCmd & running & secDwell;
  wire posOvrPassed = passed(curPos, ovrTarget, dirForward);

  logic        spdInRange;
  logic [31:0] spdUse;
  logic        pscInRange;
  logic [31:0] pscUse;

  aosc_speed_sel uSpd (
    .reqSpeed  (speedOverrideVal),
    .biasSpeed (biasSpeed),
    .inRange   (spdInRange),
    .useSpeed  (spdUse)
  );

  aosc_speed_sel uPsc (
    .reqSpeed  (pscSpeed),
    .biasSpeed (biasSpeed),
    .inRange   (pscInRange),
    .useSpeed  (pscUse)
  );

  wire spdOk  = speed_override_cmd & running & (secAcc | secConst) &
                spdInRange;
  wire spdErr = speed_override_cmd & running & (secDec | secDwell);
  wire pscOk  = speed_change_at_position_cmd & running & modeEndContSeq &
                (secAcc | secConst) & pscInRange;
  wire pscHit = pscArm_r & running &
                !passed(pscPos_r, curPos, dirForward);

  // Soft limits: off in homing and speed mode, need a set origin.
  wire swCheck = moving & !inHome & !inSpeed & origin_r;
  wire swUpHit = swCheck & (curPos > swUpper);
  wire swLoHit = swCheck & (curPos < swLower);

  // External limits act on the rising edge; jog only toward limit.
  wire extUpRise = pinLvl[0] & ~extPrev_r[0];
  wire extLoRise = pinLvl[1] & ~extPrev_r[1];
  wire extUpHit  = extUpRise & moving & (!jogActive | dirForward);
  wire extLoHit  = extLoRise & moving & (!jogActive | !dirForward);
  wire extWrong  = (extUpHit & !dirForward) | (extLoHit & dirForward);

  // Dog and home pins count only until homing has completed.
  assign dogHomeUse = !homingDone & (pinLvl[2] | pinLvl[3]);

  // Immediate causes beat a deceleration stop.
  wire immStop = estopCmd | extUpHit | extLoHit | swUpHit | swLoHit;
  // A stop on any joined axis stops this one too.
  wire decStop = decStopCmd | (interpActive & peerStop);

  // ****************************************************************
  // Stop state machine.
  // ****************************************************************
  always_comb begin
    stop_nxt = stop_r;
    case (stop_r)
      ST_RUN: begin
        if (estopCmd | extUpHit | extLoHit) begin
          stop_nxt = ST_NOOUT;
        end else if (immStop) begin
          stop_nxt = ST_HALT;
        end else if (decStop | (posOvrOk & posOvrPassed)) begin
          stop_nxt = ST_DECSTP;
        end
      end
      ST_DECSTP: begin
        if (estopCmd | extUpHit | extLoHit) begin
          stop_nxt = ST_NOOUT;
        end else if (immStop) begin
          stop_nxt = ST_HALT;
        end else if (stopped) begin
          stop_nxt = ST_RUN;
        end
      end
      ST_HALT: begin
        if (estopCmd) begin
          stop_nxt = ST_NOOUT;
        end else if (startCmd) begin
          stop_nxt = ST_RUN;
        end
      end
      ST_NOOUT: begin
        if (cancelNoOutCmd & !estopCmd) begin
          stop_nxt = ST_HALT;
        end
      end
      default: stop_nxt = ST_RUN;
    endcase
  end

  // Error code selection, most severe first.
  logic [15:0] errSel;
  always_comb begin
    errSel = err_r;
    if (estopCmd) begin
      errSel = `AOSC_ERR_ESTOP;
    end else if (extWrong) begin
      errSel = `AOSC_ERR_EXT_DIR;
    end else if (extUpHit) begin
      errSel = `AOSC_ERR_EXT_UP;
    end else if (extLoHit) begin
      errSel = `AOSC_ERR_EXT_LO;
    end else if (swUpHit) begin
      errSel = `AOSC_ERR_SW_UP;
    end else if (swLoHit) begin
      errSel = `AOSC_ERR_SW_LO;
    end else if (posOvrErr) begin
      errSel = `AOSC_ERR_POS_OVR;
    end else if (spdErr) begin
      errSel = `AOSC_ERR_SPD_OVR;
    end else if (cancelNoOutCmd & (stop_r == ST_NOOUT)) begin
      errSel = `AOSC_ERR_NONE;
    end
  end

  // Start target: absolute restart moves remainder, incremental full.
  aosc_pos_t startTarget;
  assign startTarget = absStep ? stepTarget :
                       (restartSame ? curPos + stepTarget :
                                      curPos + stepTarget);
  // Absolute target is fixed, so remainder follows from curPos itself.

  // ****************************************************************
  // Step registers.
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      stop_r     <= ST_RUN;
      startPos_r <= '0;
      target_r   <= '0;
      speed_r    <= `AOSC_SPD_RST;
      pscPos_r   <= '0;
      pscSpeed_r <= `AOSC_SPD_RST;
      pscArm_r   <= 1'b0;
      err_r      <= `AOSC_ERR_NONE;
      extPrev_r  <= 2'b00;
    end else begin
      stop_r    <= stop_nxt;
      err_r     <= errSel;
      extPrev_r <= pinLvl[1:0];
      if (startCmd & (stop_r != ST_NOOUT)) begin
        startPos_r <= curPos;
        target_r   <= startTarget;
        speed_r    <= stepSpeed;
        pscArm_r   <= 1'b0;
      end else begin
        if (continuous_pattern & stepDone) begin
          startPos_r <= curPos;
        end
        if (posOvrOk & !posOvrPassed) begin
          target_r <= ovrTarget;
        end
        if (spdOk) begin
          speed_r <= spdUse;
        end else if (pscHit) begin
          speed_r <= pscSpeed_r;
        end
        if (pscOk) begin
          pscPos_r   <= pscPos;
          pscSpeed_r <= pscUse;
          pscArm_r   <= 1'b1;
        end else if (pscHit | !running) begin
          pscArm_r <= 1'b0;
        end
      end
    end
  end

  // ****************************************************************
  // Origin, completion and auxiliary code.
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      origin_r     <= 1'b0;
      done_r       <= 1'b0;
      aux_r        <= 1'b0;
      auxClr_r     <= 1'b0;
      decStopped_r <= 1'b0;
    end else begin
      if (estopCmd) begin
        origin_r <= 1'b0;
      end else if (originSet) begin
        origin_r <= 1'b1;
      end
      if (stop_r == ST_DECSTP) begin
        decStopped_r <= 1'b1;
      end else if (startCmd) begin
        decStopped_r <= 1'b0;
      end
      // No completion after a deceleration stop.
      done_r   <= stepDone & running & !decStopped_r;
      aux_r    <= stepDone & running & !decStopped_r;
      auxClr_r <= estopCmd;
    end
  end

  // ****************************************************************
  // Outputs.
  // ****************************************************************
  assign targetPos   = target_r;
  assign runSpeed    = speed_r;
  assign decelReq    = stop_r == ST_DECSTP;
  assign haltReq     = (stop_r == ST_HALT) | (stop_r == ST_NOOUT);
  assign pulseEnable = stop_r != ST_NOOUT;
  assign noOutput    = stop_r == ST_NOOUT;
  assign stopPeers   = interpActive & (stop_r != ST_RUN);
  assign posDone     = done_r;
  assign auxAfterOn  = aux_r;
  assign auxCodeClr  = auxClr_r;
  assign originValid = origin_r;
  assign errCode     = err_r;

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  a_estop_noout: assert property (@(posedge clk_sys) disable iff (rst)
    estopCmd |=> noOutput && !pulseEnable && errCode == 16'h01e1)
    else $error("Emergency stop did not force no output.");

  a_cancel_clear: assert property (@(posedge clk_sys) disable iff (rst)
    (noOutput && cancelNoOutCmd && !estopCmd) |=>
      !noOutput && errCode == 16'h0000)
    else $error("Cancel did not clear no output and error.");

  a_dwell_por: assert property (@(posedge clk_sys) disable iff (rst)
    posOvrErr && !immStop |=> errCode == 16'h016a)
    else $error("Dwell override missed error code.");

  a_spd_reject: assert property (@(posedge clk_sys) disable iff (rst)
    spdErr && !immStop && !posOvrErr && !startCmd && !pscHit |=>
      errCode == 16'h0179 && $stable(runSpeed))
    else $error("Speed override in dec or dwell mishandled.");

  a_bias_clamp: assert property (@(posedge clk_sys) disable iff (rst)
    spdOk && !startCmd |=> runSpeed >= biasSpeed)
    else $error("Override speed fell below bias.");

  a_pos_retarget: assert property (@(posedge clk_sys) disable iff (rst)
    posOvrOk && !posOvrPassed && !startCmd |=>
      targetPos == $past(startPos_r) + $past(posOverrideAmt))
    else $error("Override target not start plus amount.");

  a_decstop_nodone: assert property (@(posedge clk_sys) disable iff (rst)
    decelReq |=> !posDone && !auxAfterOn)
    else $error("Completion raised after deceleration stop.");

  a_imm_priority: assert property (@(posedge clk_sys) disable iff (rst)
    decelReq && immStop |=> haltReq)
    else $error("Immediate stop lost to deceleration stop.");

  a_origin_lost: assert property (@(posedge clk_sys) disable iff (rst)
    estopCmd |=> !originValid)
    else $error("Origin still valid after emergency stop.");

  a_swlim_home: assert property (@(posedge clk_sys) disable iff (rst)
    (inHome || inSpeed) && running && !estopCmd && !extUpHit &&
      !extLoHit |=> !haltReq)
    else $error("Soft limit checked in homing or speed mode.");

endmodule // aosc_axis_ctrl

// ==== verification/aosc_drive_model.sv ====
/*
 Drive-side model of one axis: motion section, position and rest state.
 Assumes the bench sets the wanted section and position on clk_sys.
*/
`timescale 1ns/10ps

module aosc_drive_model (
  // Clock and reset.
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Requests from the axis block and the bench.
  input  wire logic        pulseEnable,
  input  wire logic        decelReq,
  input  wire logic        haltReq,
  input  wire logic [4:0]  secReq,
  input  wire logic [31:0] posVal,
  // Status back to the axis block.
  output logic      [4:0]  section,
  output logic             stopped,
  output logic      [31:0] curPos
);
  logic [2:0] decCnt_r;

  always_ff @(posedge clk_sys) begin
    curPos <= posVal;
    if (rst || !pulseEnable || haltReq) begin
      section  <= 5'h01;
      decCnt_r <= 3'h0;
    end else if (decelReq) begin
      decCnt_r <= decCnt_r + 3'h1;
      section  <= (decCnt_r >= 3'h3) ? 5'h01 : 5'h08;
    end else begin
      decCnt_r <= 3'h0;
      section  <= secReq;
    end
  end

  assign stopped = (section == 5'h01);
endmodule // aosc_drive_model

// ==== verification/tb_axis_override_and_stop_control.sv ====
/*
 Bench for the axis override and stop control block.
 Assumes the drive model supplies section, position and rest state.
*/
`timescale 1ns/10ps

module tb_axis_override_and_stop_control
  import aosc_pkg::*;
;
  logic clk_sys, rst, extUpperPin, extLowerPin, dogPin, homePin;
  logic [4:0] section, secReq;
  logic [2:0] opMode;
  logic jogActive, interpActive, dirForward, stepDone, stopped;
  logic [1:0] patternSel;
  logic absStep, continuous_pattern, modeEndContSeq, homingDone;
  logic originSet, startCmd, restartSame, posOverrideCmd;
  logic speed_override_cmd, speed_change_at_position_cmd;
  logic decStopCmd, estopCmd, peerStop, cancelNoOutCmd, doneSeen;
  logic [31:0] biasSpeed, stepSpeed, speedOverrideVal, pscSpeed, posVal;
  aosc_pos_t curPos, swUpper, swLower, stepTarget, posOverrideAmt;
  aosc_pos_t pscPos, targetPos;
  logic [31:0] runSpeed;
  logic decelReq, haltReq, pulseEnable, stopPeers, posDone, auxAfterOn;
  logic auxCodeClr, noOutput, originValid, dogHomeUse;
  logic [15:0] errCode;
  int fail_count = 0;
  int compares = 0;
  logic [31:0] spIn [5] = '{32'h1f4, 32'h186a0, 32'h186a1, 32'h0, 32'h32};
  logic [31:0] spEx [5] = '{32'h1f4, 32'h186a0, 32'h186a0, 32'h186a0, 32'h64};

  aosc_axis_ctrl dut (.*);
  aosc_drive_model drv (.*);

  initial begin
    clk_sys = 0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  always @(negedge clk_sys) doneSeen |= posDone;

  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic fire(ref logic s);
    s = 1;
    tick(1);
    s = 0;
    tick(1);
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    {extUpperPin, extLowerPin, dogPin, homePin, jogActive} = '0;
    {interpActive, stepDone, restartSame, originSet, startCmd} = '0;
    {posOverrideCmd, speed_override_cmd, speed_change_at_position_cmd} = '0;
    {decStopCmd, estopCmd, peerStop, cancelNoOutCmd, homingDone} = '0;
    {continuous_pattern, doneSeen, patternSel} = '0;
    {dirForward, absStep, modeEndContSeq, rst} = '1;
    opMode = 3'h1;
    secReq = 5'h01;
    biasSpeed = 32'h64;
    stepSpeed = 32'h3e8;
    speedOverrideVal = 32'h0;
    pscSpeed = 32'h0;
    swUpper = 32'sh186a0;
    swLower = -32'sh186a0;
    {stepTarget, posOverrideAmt, pscPos} = '0;
    posVal = 32'h4e20;
    tick(5);
    rst = 0;
    tick(1);
    chk("errCode", 32'h0, errCode);
    chk("pulseEnable", 32'h1, pulseEnable);
    dogPin = 1;
    tick(5);
    chk("dogHomeUse", 32'h1, dogHomeUse);
    homingDone = 1;
    tick(1);
    chk("dogHomeUse", 32'h0, dogHomeUse);
    dogPin = 0;
    $display("test reset done");
    stepTarget = 32'sh9c40;
    fire(startCmd);
    secReq = 5'h02;
    posVal = 32'h7530;
    tick(2);
    posOverrideAmt = 32'sh3a98;
    fire(posOverrideCmd);
    chk("targetPos", 32'h88b8, targetPos);
    posVal = 32'h9470;
    tick(2);
    doneSeen = 0;
    fire(posOverrideCmd);
    chk("decelReq", 32'h1, decelReq);
    secReq = 5'h01;
    tick(8);
    chk("decelReq", 32'h0, decelReq);
    chk("posDone", 32'h0, doneSeen);
    secReq = 5'h10;
    tick(2);
    fire(posOverrideCmd);
    chk("errCode", 32'h16a, errCode);
    interpActive = 1;
    fire(peerStop);
    chk("decelReq", 32'h1, decelReq);
    chk("haltReq", 32'h0, haltReq);
    chk("stopPeers", 32'h1, stopPeers);
    tick(8);
    chk("stopPeers", 32'h0, stopPeers);
    interpActive = 0;
    $display("test position override done");
    secReq = 5'h04;
    tick(2);
    for (int i = 0; i < 5; i++) begin
      speedOverrideVal = spIn[i];
      fire(speed_override_cmd);
      chk("runSpeed", spEx[i], runSpeed);
    end
    secReq = 5'h08;
    tick(2);
    speedOverrideVal = 32'h2bc;
    fire(speed_override_cmd);
    chk("errCode", 32'h179, errCode);
    chk("runSpeed", 32'h64, runSpeed);
    secReq = 5'h04;
    pscPos = 32'sh9858;
    pscSpeed = 32'h1f4;
    tick(2);
    fire(speed_change_at_position_cmd);
    chk("runSpeed", 32'h64, runSpeed);
    posVal = 32'h9858;
    tick(2);
    chk("runSpeed", 32'h1f4, runSpeed);
    $display("test speed override done");
    opMode = 3'h2;
    fire(originSet);
    chk("originValid", 32'h1, originValid);
    secReq = 5'h02;
    posVal = 32'h186a1;
    tick(3);
    chk("errCode", 32'h179, errCode);
    opMode = 3'h1;
    tick(3);
    chk("errCode", 32'h1f5, errCode);
    chk("haltReq", 32'h1, haltReq);
    $display("test soft limit done");
    estopCmd = 1;
    tick(1);
    chk("auxCodeClr", 32'h1, auxCodeClr);
    estopCmd = 0;
    tick(1);
    chk("noOutput", 32'h1, noOutput);
    chk("pulseEnable", 32'h0, pulseEnable);
    chk("errCode", 32'h1e1, errCode);
    chk("originValid", 32'h0, originValid);
    fire(cancelNoOutCmd);
    chk("noOutput", 32'h0, noOutput);
    chk("errCode", 32'h0, errCode);
    $display("test emergency stop done");
    posVal = 32'h0;
    fire(startCmd);
    doneSeen = 0;
    fire(stepDone);
    chk("posDone", 32'h1, doneSeen);
    tick(2);
    extUpperPin = 1;
    tick(8);
    chk("errCode", 32'h1ec, errCode);
    chk("noOutput", 32'h1, noOutput);
    extUpperPin = 0;
    fire(cancelNoOutCmd);
    $display("test external limit done");
    close_out();
  end

  initial begin
    #100000;
    fail_count++;
    $display("Error watchdog expected finish seen hang");
    close_out();
  end
endmodule // tb_axis_override_and_stop_control
